// ### core/bpm_pm_cap.v
// power-management capability structure of a root-port bridge function
// assumes byte-wide configuration accesses on the same clock, strobes
// one cycle long and never both at once
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "bpm_defs.vh"
module bpm_pm_cap (
    input wire clk,
    input wire rst,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    input wire cfg_wr,
    input wire cfg_rd,
    output reg [7:0] cfg_rdata,
    output reg cfg_hit,
    output reg [1:0] pm_power_state,
    output reg pm_wake_enable,
    output reg pm_wake_status,
    output reg pm_wake_request
);

    // ==========================================================
    // capabilities word built field by field

    localparam [15:0] CAPA_WAKE = {11'h000, `BPM_CAPA_WAKE_VAL} << `BPM_CAPA_WAKE_LSB;
    localparam [15:0] CAPA_D2 = 16'h0000 & (16'h0001 << `BPM_CAPA_D2_BIT);
    localparam [15:0] CAPA_D1 = 16'h0000 & (16'h0001 << `BPM_CAPA_D1_BIT);
    localparam [15:0] CAPA_AUX = {13'h0000, `BPM_CAPA_AUX_VAL} << `BPM_CAPA_AUX_LSB;
    localparam [15:0] CAPA_DSI = 16'h0001 << `BPM_CAPA_DSI_BIT;
    localparam [15:0] CAPA_RSVD = 16'h0000 & (16'h0001 << `BPM_CAPA_RSVD_BIT);
    localparam [15:0] CAPA_CLK = 16'h0000 & (16'h0001 << `BPM_CAPA_CLK_BIT);
    localparam [15:0] CAPA_VER = {13'h0000, `BPM_CAPA_VER_VAL} << `BPM_CAPA_VER_LSB;

    // assembled word; should equal the documented reset image
    localparam [15:0] CAPA_WORD = CAPA_WAKE | CAPA_D2 | CAPA_D1 | CAPA_AUX |
        CAPA_DSI | CAPA_RSVD | CAPA_CLK | CAPA_VER;

    // ==========================================================
    // status/control word reset image and write mask

    localparam [15:0] CSR_WSTAT_RST = 16'h0000 & (16'h0001 << `BPM_CSR_WSTAT_BIT);
    localparam [15:0] CSR_DATA_RST = 16'h0000 & (16'h001F << `BPM_CSR_SEL_LSB);
    localparam [15:0] CSR_WEN_RST = 16'h0000 & (16'h0001 << `BPM_CSR_WEN_BIT);
    localparam [15:0] CSR_PSTATE_RST = {14'h0000, `BPM_PSTATE_D0} << `BPM_CSR_PSTATE_LSB;

    localparam [15:0] CSR_WORD = `BPM_CSR_RST | CSR_WSTAT_RST | CSR_DATA_RST |
        CSR_WEN_RST | CSR_PSTATE_RST;

    // ==========================================================
    // per-lane images, lane 0 at the lowest offset

    localparam [7:0] LANE0_RST = `BPM_CAPABILITY_IDENTIFIER_VAL;
    localparam [7:0] LANE1_RST = `BPM_NEXT_PTR_VAL;

    localparam [47:0] LANE_RST = {CSR_WORD, CAPA_WORD, LANE1_RST, LANE0_RST};

    // every byte of this structure is read-only from the bus; the status
    // word mask is kept so a future writable bit needs one constant only
    localparam [47:0] LANE_WR_MASK = {`BPM_CSR_WR_MASK, 16'h0000, 8'h00, 8'h00};

    // ==========================================================
    // address decode, shared by the read and write paths

    // lane number for an address, or the lane count when unmapped
    function [2:0] lane_of;
        input [7:0] addr;
        begin
            case (addr)
                `BPM_OFF_CAPABILITY_IDENTIFIER: lane_of = 3'h0;
                `BPM_OFF_NEXT_PTR: lane_of = 3'h1;
                `BPM_OFF_CAPA_LO: lane_of = 3'h2;
                `BPM_OFF_CAPA_HI: lane_of = 3'h3;
                `BPM_OFF_CSR_LO: lane_of = 3'h4;
                `BPM_OFF_CSR_HI: lane_of = 3'h5;
                default: lane_of = 3'h6;
            endcase
        end
    endfunction

    // true when an address falls on one of our six bytes
    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = (lane_of(addr) != 3'h6);
        end
    endfunction

    wire [2:0] acc_lane;
    wire acc_mapped;

    // one decode serves both strobes, they never come together
    assign acc_lane = lane_of(cfg_addr);
    assign acc_mapped = is_mapped(cfg_addr);

    // ==========================================================
    // byte lanes

    wire [47:0] lane_val;
    wire [`BPM_NUM_LANES-1:0] lane_wr;

    genvar g;
    generate
        for (g = 0; g < `BPM_NUM_LANES; g = g + 1) begin : g_lane
            assign lane_wr[g] = cfg_wr && acc_mapped && (acc_lane == g);

            bpm_cfg_byte #(
                .RESET_VAL(LANE_RST[g*8 +: 8]),
                .WR_MASK(LANE_WR_MASK[g*8 +: 8])
            ) u_byte (
                .clk(clk),
                .rst(rst),
                .wr_en(lane_wr[g]),
                .wr_data(cfg_wdata),
                .value(lane_val[g*8 +: 8])
            );
        end
    endgenerate

    // ==========================================================
    // words seen by the rest of the function

    wire [15:0] capa_word;
    wire [15:0] csr_word;

    assign capa_word = lane_val[31:16];
    assign csr_word = lane_val[47:32];

    // ==========================================================
    // read path

    reg [7:0] rd_sel;

    always @* begin
        rd_sel = 8'h00;
        case (acc_lane)
            3'h0: rd_sel = lane_val[7:0];
            3'h1: rd_sel = lane_val[15:8];
            3'h2: rd_sel = capa_word[7:0];
            3'h3: rd_sel = capa_word[15:8];
            3'h4: rd_sel = csr_word[7:0];
            3'h5: rd_sel = csr_word[15:8];
            default: rd_sel = 8'h00; // unmapped reads as zero
        endcase
    end

    reg [7:0] rdata_d;
    reg hit_d;

    // data stands only in the cycle after the read strobe
    always @* begin
        rdata_d = 8'h00;
        hit_d = 1'b0;
        if (cfg_rd) begin
            rdata_d = rd_sel;
            hit_d = acc_mapped;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
            cfg_hit <= 1'b0;
        end else begin
            cfg_rdata <= rdata_d;
            cfg_hit <= hit_d;
        end
    end

    // ==========================================================
    // power-state view for the rest of the function

    reg [1:0] pstate_d;
    reg wen_d;
    reg wstat_d;

    // fields taken from the stored word, not from constants, so a
    // stuck byte would show here as well as on reads
    always @* begin
        pstate_d = csr_word[`BPM_CSR_PSTATE_LSB +: 2];
        wen_d = csr_word[`BPM_CSR_WEN_BIT];
        wstat_d = csr_word[`BPM_CSR_WSTAT_BIT];
    end

    // registered outputs; wake only when both enable and status set
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pm_power_state <= `BPM_PSTATE_D0;
            pm_wake_enable <= 1'b0;
            pm_wake_status <= 1'b0;
            pm_wake_request <= 1'b0;
        end else begin
            pm_power_state <= pstate_d;
            pm_wake_enable <= wen_d;
            pm_wake_status <= wstat_d;
            pm_wake_request <= wen_d & wstat_d;
        end
    end

endmodule // bpm_pm_cap

// ### common/bpm_defs.vh
// constants of the bridge power-management capability structure
// assumes byte-wide configuration accesses at the printed offsets
//
// What this block does
// - capability identifier byte reads fixed 01h, read-only
// - next pointer byte reads fixed 58h, writes ignored
// - wake-support bits 15:11 read 11001b: wake from D0, D3 hot, D3 cold
// - capability bit 10 reads zero: no D2 state
// - capability bit 9 reads zero: no D1 state
// - auxiliary-current bits 8:6 read 000b: self-powered
// - capability bit 5 reads one: device-specific init needed
// - capability bit 3 reads zero: no bus clock needed for wake
// - version bits 2:0 read 010b: power-management revision 1.1
// - wake-status bit 15 unimplemented, reads zero, read-only
// - data-scale 14:13 and data-select 12:9 read zero, ignore writes
// - wake-enable bit 8 ignores writes, stays zero, never wakes
// - power-state bits 1:0 always read 00b (D0), writes ignored
`ifndef BPM_DEFS_VH
`define BPM_DEFS_VH

// ==========================================================
// byte offsets in configuration space
`define BPM_OFF_CAPABILITY_IDENTIFIER 8'h50
`define BPM_OFF_NEXT_PTR 8'h51
`define BPM_OFF_CAPA_LO 8'h52
`define BPM_OFF_CAPA_HI 8'h53
`define BPM_OFF_CSR_LO 8'h54
`define BPM_OFF_CSR_HI 8'h55
`define BPM_NUM_LANES 6

// ==========================================================
// header byte values
`define BPM_CAPABILITY_IDENTIFIER_VAL 8'h01
`define BPM_NEXT_PTR_VAL 8'h58

// ==========================================================
// capabilities word fields
`define BPM_CAPA_WAKE_LSB 11
`define BPM_CAPA_WAKE_VAL 5'h19
`define BPM_CAPA_D2_BIT 10
`define BPM_CAPA_D1_BIT 9
`define BPM_CAPA_AUX_LSB 6
`define BPM_CAPA_AUX_VAL 3'h0
`define BPM_CAPA_DSI_BIT 5
`define BPM_CAPA_RSVD_BIT 4
`define BPM_CAPA_CLK_BIT 3
`define BPM_CAPA_VER_LSB 0
`define BPM_CAPA_VER_VAL 3'h2
`define BPM_CAPA_RST 16'hC822

// ==========================================================
// status/control word fields
`define BPM_CSR_WSTAT_BIT 15
`define BPM_CSR_SCALE_LSB 13
`define BPM_CSR_SEL_LSB 9
`define BPM_CSR_WEN_BIT 8
`define BPM_CSR_PSTATE_LSB 0
`define BPM_CSR_RST 16'h0000
`define BPM_PSTATE_D0 2'h0
// no bit of the status/control word accepts a write
`define BPM_CSR_WR_MASK 16'h0000

`endif

// ### core/bpm_cfg_byte.v
// one configuration byte with a per-bit write mask
// assumes a write enable from logic on the same clock
`timescale 1ns/1ns
module bpm_cfg_byte #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WR_MASK = 8'h00
) (
    input wire clk,
    input wire rst,
    input wire wr_en,
    input wire [7:0] wr_data,
    output wire [7:0] value
);
    reg [7:0] value_q;
    reg [7:0] value_d;

    // ==========================================================
    // next value: only masked bits take the write
    always @* begin
        value_d = value_q;
        if (wr_en) begin
            value_d = (value_q & ~WR_MASK) | (wr_data & WR_MASK);
        end
    end

    // storage; a mask of zero makes the byte a constant
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule // bpm_cfg_byte

// ### dv/bpm_pm_cap_sva.sv
// checker for the power-management capability byte port
// assumes one clock that keeps running through reset
`timescale 1ns/1ns
module bpm_pm_cap_chk (
    input wire clk,
    input wire rst,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_rdata,
    input wire cfg_hit,
    input wire [1:0] pm_power_state,
    input wire pm_wake_enable,
    input wire pm_wake_status,
    input wire pm_wake_request
);
    // ==================================================
    // read answers, one cycle after the strobe
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    capability_identifier_read_a: assert property (cfg_rd && cfg_addr == 8'h50 |=> cfg_hit && cfg_rdata == 8'h01)
        else $error("capability id byte wrong");
    next_ptr_read_a: assert property (cfg_rd && cfg_addr == 8'h51 |=> cfg_rdata == 8'h58)
        else $error("next pointer byte wrong");
    capa_low_a: assert property (cfg_rd && cfg_addr == 8'h52 |=> cfg_rdata == 8'h22)
        else $error("capabilities low byte wrong");
    capa_high_a: assert property (cfg_rd && cfg_addr == 8'h53 |=> cfg_rdata == 8'hC8)
        else $error("capabilities high byte wrong");
    csr_read_zero_a: assert property (cfg_rd && cfg_addr[7:1] == 7'h2A |=> cfg_hit && cfg_rdata == 8'h00)
        else $error("status control byte not zero");
    csr_write_ignored_a: assert property (cfg_wr && cfg_addr == 8'h54 ##1 cfg_rd && cfg_addr == 8'h54 |=> cfg_rdata == 8'h00)
        else $error("status control write took effect");
    unmapped_read_a: assert property (cfg_rd && (cfg_addr < 8'h50 || cfg_addr > 8'h55) |=> !cfg_hit && cfg_rdata == 8'h00)
        else $error("unmapped read answered");
    idle_bus_quiet_a: assert property (!cfg_rd |=> !cfg_hit && cfg_rdata == 8'h00)
        else $error("read data without a read");
    // no wake and no state change can ever be requested
    pm_fixed_a: assert property (pm_power_state == 2'h0 && !pm_wake_enable && !pm_wake_status && !pm_wake_request)
        else $error("power state or wake output moved");
endmodule // bpm_pm_cap_chk

bind bpm_pm_cap bpm_pm_cap_chk i_bpm_pm_cap_chk (.clk(clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .cfg_hit(cfg_hit), .pm_power_state(pm_power_state), .pm_wake_enable(pm_wake_enable),
    .pm_wake_status(pm_wake_status), .pm_wake_request(pm_wake_request));

// ### dv/tb_bpm_pm_cap.sv
// self-checking bench for the power-management capability structure
// assumes the byte port answers a read one cycle later, writes ignored
`timescale 1ns/1ns
module tb_bpm_pm_cap;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_rdata;
    logic cfg_hit;
    logic [1:0] pm_power_state;
    logic pm_wake_enable;
    logic pm_wake_status;
    logic pm_wake_request;
    logic [7:0] exp_q = 8'h00;
    logic hit_q = 1'b0;
    int error_cnt = 0;
    int checked = 0;
    int i;

    bpm_pm_cap i_bpm_pm_cap (.clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
        .pm_power_state(pm_power_state), .pm_wake_enable(pm_wake_enable),
        .pm_wake_status(pm_wake_status), .pm_wake_request(pm_wake_request));

    // ==================================================
    // clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    // ==================================================
    // expected byte at each offset, built field by field
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        logic [15:0] capa;
        capa = {5'b11001, 1'b0, 1'b0, 3'b000, 1'b1, 1'b0, 1'b0, 3'b010};
        case (a)
            8'h50: exp_byte = 8'h01;
            8'h51: exp_byte = 8'h58;
            8'h52: exp_byte = capa[7:0];
            8'h53: exp_byte = capa[15:8];
            default: exp_byte = 8'h00;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one bus cycle; checks the answer to the previous cycle at mid-period
    task automatic step(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
        cfg_rd <= rd;
        cfg_wr <= wr;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(negedge clk);
        chk("cfg_rdata", cfg_rdata, exp_q);
        chk("cfg_hit", {7'h00, cfg_hit}, {7'h00, hit_q});
        chk("pm_outputs", {4'h0, pm_power_state, pm_wake_enable, pm_wake_status},
            8'h00);
        chk("pm_wake_request", {7'h00, pm_wake_request}, 8'h00);
        exp_q = rd ? exp_byte(a) : 8'h00;
        hit_q = rd && a >= 8'h50 && a <= 8'h55;
        @(posedge clk);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        exp_q = 8'h00;
        hit_q = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================
    // main sequence
    initial begin
        void'($urandom(9494));
        do_reset();
        // back-to-back reads across the structure and its neighbours
        for (i = 8'h4E; i <= 8'h59; i++) step(1'b1, 1'b0, i[7:0], 8'h00);
        // writes of all ones straight before a read of the same byte
        for (i = 8'h50; i <= 8'h55; i++) begin
            step(1'b0, 1'b1, i[7:0], 8'hFF);
            step(1'b1, 1'b0, i[7:0], 8'h00);
        end
        // random mix; writes must never change what reads return
        for (i = 0; i < 400; i++) begin
            case ($urandom % 3)
                0: step(1'b1, 1'b0, 8'h4C + 8'($urandom % 16), 8'h00);
                1: step(1'b0, 1'b1, 8'h4C + 8'($urandom % 16), 8'($urandom));
                default: step(1'b0, 1'b0, 8'($urandom), 8'($urandom));
            endcase
        end
        // reset in mid-run, then the structure reads the same again
        do_reset();
        for (i = 8'h50; i <= 8'h56; i++) step(1'b1, 1'b0, i[7:0], 8'h00);
        step(1'b0, 1'b0, 8'h00, 8'h00);
        summarize();
    end
endmodule // tb_bpm_pm_cap
